// ### src/calbx_pkg.sv
/*
  Package for the arithmetic, logic and branch execution block: operation
  codes, flag positions, cycle counts and the register map.
  Assumes an APB master with 32-bit data and word-aligned registers.
*/
package calbx_pkg;

  typedef enum logic [4:0] {
    CALBX_ADD_OP,
    CALBX_SUM_CARRY_OP,
    pair_sum_imm_op,
    CALBX_SUB_OP,
    difference_imm_op,
    difference_with_borrow_op,
    difference_imm_borrow_op,
    pair_difference_imm_op,
    CALBX_AND_OP,
    conjunction_imm_op,
    CALBX_OR_OP,
    disjunction_imm_op,
    CALBX_XOR_OP,
    bitwise_invert_op,
    arith_invert_op,
    mask_set_bits_op,
    mask_clear_bits_op,
    self_conjunction_test_op,
    unsigned_product_op,
    signed_product_op,
    mixed_sign_product_op,
    fraction_unsigned_product_op,
    fraction_signed_product_op,
    fraction_mixed_product_op,
    relative_jump_op,
    pointer_jump_op,
    absolute_jump_op,
    relative_subroutine_op,
    pointer_subroutine_op,
    CALBX_ABS_CALL_OP,
    subroutine_exit_op,
    CALBX_NOP_OP
  } calbx_op_t;

  // Flag bit positions in the status byte
  localparam int CALBX_FC = 0;
  localparam int CALBX_FZ = 1;
  localparam int CALBX_FN = 2;
  localparam int CALBX_FV = 3;
  localparam int CALBX_FS = 4;
  localparam int CALBX_FH = 5;

  localparam logic [7:0] CALBX_ALL_ONES = 8'hFF;

  // Cycle counts
  localparam logic [2:0] CALBX_CYC1 = 3'h1;
  localparam logic [2:0] CALBX_CYC2 = 3'h2;
  localparam logic [2:0] CALBX_CYC3 = 3'h3;
  localparam logic [2:0] CALBX_CYC4 = 3'h4;

  // Register byte addresses
  localparam logic [7:0] CALBX_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] CALBX_OPND_ADDR   = 8'h04;
  localparam logic [7:0] CALBX_PAIR_ADDR   = 8'h08;
  localparam logic [7:0] CALBX_RES_ADDR    = 8'h0C;
  localparam logic [7:0] CALBX_SREG_ADDR   = 8'h10;
  localparam logic [7:0] CALBX_PC_ADDR     = 8'h14;
  localparam logic [7:0] CALBX_STAT_ADDR   = 8'h18;

  localparam logic [7:0] CALBX_SREG_RESET = 8'h00;
  localparam logic [15:0] CALBX_PC_RESET  = 16'h0000;

  // Control register fields
  localparam int CALBX_CTRL_GO  = 8;
  localparam int CALBX_OP_LSB   = 0;
  localparam int CALBX_OP_W     = 5;

endpackage

// ### src/calbx_alu_if.sv
/*
  Interface carrying one operation request from the register front end to
  the execution core and its result back.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface calbx_alu_if;
  import calbx_pkg::*;
  calbx_op_t   op;
  logic [7:0]  dst;
  logic [7:0]  src;
  logic [7:0]  dst_hi;
  logic [15:0] ptr;
  logic [15:0] pc;
  logic [15:0] stack_top;
  logic [7:0]  sreg;
  logic [15:0] res;
  logic [7:0]  next_sreg;
  logic [15:0] next_pc;
  logic [2:0]  cycles;

  modport front (output op, dst, src, dst_hi, ptr, pc, stack_top, sreg,
                 input res, next_sreg, next_pc, cycles);
  modport core  (input op, dst, src, dst_hi, ptr, pc, stack_top, sreg,
                 output res, next_sreg, next_pc, cycles);
endinterface
`default_nettype wire

// ### src/calbx_core.sv
/*
  Combinational execution core: result, flags, next program counter and
  cycle cost of one operation.
  Assumes the caller holds operands stable while it reads the outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module calbx_core (
  calbx_alu_if.core a
);
  import calbx_pkg::*;

  function automatic logic [7:0] sub_flags(input logic [7:0] d,
      input logic [7:0] k, input logic [7:0] r, input logic [7:0] s,
      input logic zkeep);
    logic [7:0] f;
    f = s;
    f[CALBX_FH] = (~d[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~d[3]);
    f[CALBX_FC] = (~d[7] & k[7]) | (k[7] & r[7]) | (r[7] & ~d[7]);
    f[CALBX_FV] = (d[7] & ~k[7] & ~r[7]) | (~d[7] & k[7] & r[7]);
    f[CALBX_FN] = r[7];
    f[CALBX_FZ] = (r == 8'h00) & zkeep;
    f[CALBX_FS] = f[CALBX_FN] ^ f[CALBX_FV];
    return f;
  endfunction

  function automatic logic [7:0] logic_flags(input logic [7:0] r,
      input logic [7:0] s);
    logic [7:0] f;
    f = s;
    f[CALBX_FV] = 1'b0;
    f[CALBX_FN] = r[7];
    f[CALBX_FZ] = (r == 8'h00);
    f[CALBX_FS] = r[7];
    return f;
  endfunction

  logic [7:0]  d;
  logic [7:0]  k;
  logic [7:0]  s;
  logic [15:0] pair;
  logic [15:0] pres;
  logic [16:0] sprod;
  logic [8:0]  sum;
  logic [7:0]  r8;
  assign d = a.dst;
  assign k = a.src;
  assign s = a.sreg;
  assign pair = {a.dst_hi, a.dst};

  always_comb begin
    a.res       = 16'h0000;
    a.next_sreg = s;
    a.next_pc   = a.pc + 16'h0001;
    a.cycles    = CALBX_CYC1;
    sum         = 9'h000;
    r8          = 8'h00;
    pres        = 16'h0000;
    sprod       = 17'h00000;
    unique case (a.op)
      CALBX_ADD_OP, CALBX_SUM_CARRY_OP: begin
        sum = {1'b0, d} + {1'b0, k}
            + {8'h00, (a.op == CALBX_SUM_CARRY_OP) & s[CALBX_FC]};
        r8 = sum[7:0];
        a.res = {8'h00, r8};
        a.next_sreg[CALBX_FC] = sum[8];
        a.next_sreg[CALBX_FH] = (d[3] & k[3]) | (k[3] & ~r8[3])
                              | (~r8[3] & d[3]);
        a.next_sreg[CALBX_FV] = (d[7] & k[7] & ~r8[7])
                              | (~d[7] & ~k[7] & r8[7]);
        a.next_sreg[CALBX_FN] = r8[7];
        a.next_sreg[CALBX_FZ] = (r8 == 8'h00);
        a.next_sreg[CALBX_FS] = r8[7] ^ a.next_sreg[CALBX_FV];
      end
      pair_sum_imm_op, pair_difference_imm_op: begin
        // Immediate is six bits wide on the word forms
        if (a.op == pair_sum_imm_op) begin
          pres = pair + {10'h000, k[5:0]};
          a.next_sreg[CALBX_FV] = ~pair[15] & pres[15];
          a.next_sreg[CALBX_FC] = ~pres[15] & pair[15];
        end else begin
          pres = pair - {10'h000, k[5:0]};
          a.next_sreg[CALBX_FV] = pair[15] & ~pres[15];
          a.next_sreg[CALBX_FC] = pres[15] & ~pair[15];
        end
        a.res = pres;
        a.next_sreg[CALBX_FN] = pres[15];
        a.next_sreg[CALBX_FZ] = (pres == 16'h0000);
        a.next_sreg[CALBX_FS] = pres[15] ^ a.next_sreg[CALBX_FV];
        a.cycles = CALBX_CYC2;
      end
      CALBX_SUB_OP, difference_imm_op: begin
        r8 = d - k;
        a.res = {8'h00, r8};
        a.next_sreg = sub_flags(d, k, r8, s, 1'b1);
      end
      difference_with_borrow_op, difference_imm_borrow_op: begin
        r8 = d - k - {7'h00, s[CALBX_FC]};
        a.res = {8'h00, r8};
        // Zero only stays set across a multi-byte chain
        a.next_sreg = sub_flags(d, k, r8, s, s[CALBX_FZ]);
      end
      CALBX_AND_OP, conjunction_imm_op, self_conjunction_test_op,
      mask_clear_bits_op: begin
        if (a.op == self_conjunction_test_op)
          r8 = d & d;
        else if (a.op == mask_clear_bits_op)
          r8 = d & (CALBX_ALL_ONES - k);
        else
          r8 = d & k;
        a.res = {8'h00, r8};
        a.next_sreg = logic_flags(r8, s);
      end
      CALBX_OR_OP, disjunction_imm_op, mask_set_bits_op: begin
        r8 = d | k;
        a.res = {8'h00, r8};
        a.next_sreg = logic_flags(r8, s);
      end
      CALBX_XOR_OP: begin
        r8 = d ^ k;
        a.res = {8'h00, r8};
        a.next_sreg = logic_flags(r8, s);
      end
      bitwise_invert_op: begin
        r8 = CALBX_ALL_ONES - d;
        a.res = {8'h00, r8};
        a.next_sreg = logic_flags(r8, s);
        a.next_sreg[CALBX_FC] = 1'b1;
      end
      arith_invert_op: begin
        r8 = 8'h00 - d;
        a.res = {8'h00, r8};
        a.next_sreg = sub_flags(8'h00, d, r8, s, 1'b1);
      end
      unsigned_product_op, signed_product_op, mixed_sign_product_op,
      fraction_unsigned_product_op, fraction_signed_product_op,
      fraction_mixed_product_op: begin
        if (a.op == unsigned_product_op
            || a.op == fraction_unsigned_product_op)
          sprod = {9'h000, d} * {9'h000, k};
        else if (a.op == signed_product_op
            || a.op == fraction_signed_product_op)
          sprod = 17'($signed({{9{d[7]}}, d}) * $signed({{9{k[7]}}, k}));
        else
          sprod = 17'($signed({{9{d[7]}}, d}) * $signed({9'h000, k}));
        pres = sprod[15:0];
        a.next_sreg[CALBX_FC] = pres[15];
        if (a.op == fraction_unsigned_product_op
            || a.op == fraction_signed_product_op
            || a.op == fraction_mixed_product_op)
          pres = {pres[14:0], 1'b0};
        a.res = pres;
        a.next_sreg[CALBX_FZ] = (pres == 16'h0000);
        a.cycles = CALBX_CYC2;
      end
      relative_jump_op, relative_subroutine_op: begin
        a.next_pc = a.pc + {{8{k[7]}}, k} + 16'h0001;
        a.cycles = (a.op == relative_jump_op) ? CALBX_CYC2 : CALBX_CYC3;
      end
      pointer_jump_op: begin
        a.next_pc = a.ptr;
        a.cycles = CALBX_CYC2;
      end
      pointer_subroutine_op: begin
        a.next_pc = a.ptr;
        a.cycles = CALBX_CYC3;
      end
      absolute_jump_op: begin
        a.next_pc = a.ptr;
        a.cycles = CALBX_CYC3;
      end
      CALBX_ABS_CALL_OP: begin
        a.next_pc = a.ptr;
        a.cycles = CALBX_CYC4;
      end
      subroutine_exit_op: begin
        a.next_pc = a.stack_top;
        a.cycles = CALBX_CYC4;
      end
      CALBX_NOP_OP: begin
        a.cycles = CALBX_CYC1;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### src/calbx_top.sv
/*
  APB-reached execution unit for arithmetic, logic, multiply and
  unconditional program-flow operations of an 8-bit core.
  Assumes a single 50 MHz pclk and an APB3 master with 32-bit data.
*/
// Implementation choices: the APB slave port and the address map.
// Operation
// - Add with carry writes dst+src+C and sets Z,C,N,V,H in 1 cycle.
// - Pair add immediate adds K to the 16-bit pair, Z,C,N,V,S, 2 cycles.
// - Subtract immediate writes dst-K, Z,C,N,V,H in 1 cycle.
// - Register subtract with borrow writes dst-src-C in 1 cycle.
// - Immediate subtract with borrow writes dst-K-C in 1 cycle.
// - Pair subtract immediate takes K from the pair in 2 cycles.
// - AND immediate keeps dst&K and sets only Z,N,V,S in 1 cycle.
// - OR immediate keeps dst|K and sets Z,N,V in 1 cycle.
// - Test ANDs a register with itself and sets Z,N,V in 1 cycle.
// - Mask set bits ORs in a mask and sets Z,N,V in 1 cycle.
// - Mask clear bits ANDs with 0xFF-K and sets Z,N,V in 1 cycle.
// - The three multiplies put the product in the pair, Z,C, 2 cycles.
// - Fractional multiplies shift the product left once, Z,C, 2 cycles.
// - Pointer jump loads PC from the pointer, no flags, 2 cycles.
// - Pointer call loads PC from the pointer, no flags, 3 cycles.
`timescale 1ns/1ps
`default_nettype none
module calbx_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr
);
  import calbx_pkg::*;

  calbx_alu_if alu ();

  logic [4:0]  op_code;
  logic [7:0]  opnd_dst;
  logic [7:0]  opnd_src;
  logic [7:0]  opnd_hi;
  logic [15:0] ptr;
  logic [15:0] stack_top;
  logic [15:0] result;
  logic [7:0]  sreg;
  logic [15:0] pc;
  logic        busy;
  logic [2:0]  cyc_left;
  logic [2:0]  last_cycles;
  logic [15:0] done_count;

  logic wr_en;
  logic rd_en;
  logic go;
  logic addr_ok;

  function automatic logic known_addr(input logic [7:0] ad);
    return ad == CALBX_CTRL_ADDR || ad == CALBX_OPND_ADDR
        || ad == CALBX_PAIR_ADDR || ad == CALBX_RES_ADDR
        || ad == CALBX_SREG_ADDR || ad == CALBX_PC_ADDR
        || ad == CALBX_STAT_ADDR;
  endfunction

  assign addr_ok = known_addr(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok;
  assign rd_en   = psel & ~penable & ~pwrite;
  // Writes while an operation runs start nothing; the operands stay held
  assign go      = wr_en & ~busy & (paddr == CALBX_CTRL_ADDR)
                 & pwdata[CALBX_CTRL_GO];

  // The op code written together with go drives the core in that cycle
  assign alu.op        = go ? calbx_op_t'(pwdata[CALBX_OP_LSB +: CALBX_OP_W])
                            : calbx_op_t'(op_code);
  assign alu.dst       = opnd_dst;
  assign alu.src       = opnd_src;
  assign alu.dst_hi    = opnd_hi;
  assign alu.ptr       = ptr;
  assign alu.pc        = pc;
  assign alu.stack_top = stack_top;
  assign alu.sreg      = sreg;

  calbx_core u_core (
    .a (alu.core)
  );

  // Operand registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_code   <= 5'h1F;
      opnd_dst  <= 8'h00;
      opnd_src  <= 8'h00;
      opnd_hi   <= 8'h00;
      ptr       <= 16'h0000;
      stack_top <= 16'h0000;
    end else if (wr_en && !busy) begin
      if (paddr == CALBX_CTRL_ADDR)
        op_code <= pwdata[CALBX_OP_LSB +: CALBX_OP_W];
      if (paddr == CALBX_OPND_ADDR) begin
        opnd_dst <= pwdata[7:0];
        opnd_src <= pwdata[15:8];
        opnd_hi  <= pwdata[23:16];
      end
      if (paddr == CALBX_PAIR_ADDR) begin
        ptr       <= pwdata[15:0];
        stack_top <= pwdata[31:16];
      end
    end
  end

  // Commit: state lands at start, busy stays up for the cycle cost less one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result      <= 16'h0000;
      sreg        <= CALBX_SREG_RESET;
      pc          <= CALBX_PC_RESET;
      last_cycles <= 3'h0;
    end else if (go) begin
      result      <= alu.res;
      sreg        <= alu.next_sreg;
      pc          <= alu.next_pc;
      last_cycles <= alu.cycles;
    end else if (wr_en && !busy) begin
      if (paddr == CALBX_SREG_ADDR)
        sreg <= pwdata[7:0];
      if (paddr == CALBX_PC_ADDR)
        pc <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy     <= 1'b0;
      cyc_left <= 3'h0;
    end else if (go) begin
      busy     <= alu.cycles != CALBX_CYC1;
      cyc_left <= alu.cycles - CALBX_CYC1;
    end else if (busy) begin
      cyc_left <= cyc_left - 3'h1;
      busy     <= cyc_left != 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      done_count <= 16'h0000;
    else if (go)
      done_count <= done_count + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        CALBX_CTRL_ADDR: prdata <= {27'h0, op_code};
        CALBX_OPND_ADDR: prdata <= {8'h00, opnd_hi, opnd_src, opnd_dst};
        CALBX_PAIR_ADDR: prdata <= {stack_top, ptr};
        CALBX_RES_ADDR:  prdata <= {16'h0000, result};
        CALBX_SREG_ADDR: prdata <= {24'h0, sreg};
        CALBX_PC_ADDR:   prdata <= {16'h0000, pc};
        CALBX_STAT_ADDR: prdata <= {done_count, 5'h0, last_cycles,
                                    7'h0, busy};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  property p_busy_two;
    @(posedge pclk) disable iff (!presetn)
      (go && alu.cycles == CALBX_CYC2) |=> busy ##1 !busy;
  endproperty
  a_busy_two: assert property (p_busy_two)
    else $error("two-cycle op busy span wrong");

  property p_busy_three;
    @(posedge pclk) disable iff (!presetn)
      (go && alu.op == pointer_subroutine_op) |=> busy[*2] ##1 !busy;
  endproperty
  a_busy_three: assert property (p_busy_three)
    else $error("pointer call not three cycles");

  property p_one_cycle;
    @(posedge pclk) disable iff (!presetn)
      (go && alu.op == difference_imm_op) |=> !busy;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("subtract immediate not one cycle");

  property p_pointer_jump_op_pc;
    @(posedge pclk) disable iff (!presetn)
      (go && alu.op == pointer_jump_op) |=> pc == $past(ptr)
        && sreg == $past(sreg);
  endproperty
  a_pointer_jump_op_pc: assert property (p_pointer_jump_op_pc)
    else $error("pointer jump pc or flags wrong");

  property p_relative_jump_op_pc;
    @(posedge pclk) disable iff (!presetn)
      (go && alu.op == relative_jump_op) |=>
        pc == $past(pc) + {{8{$past(opnd_src[7])}}, $past(opnd_src)} + 16'h1;
  endproperty
  a_relative_jump_op_pc: assert property (p_relative_jump_op_pc)
    else $error("relative jump target wrong");

  property p_adc;
    @(posedge pclk) disable iff (!presetn)
      (go && alu.op == CALBX_SUM_CARRY_OP) |=> result[7:0] ==
        8'($past(opnd_dst) + $past(opnd_src) + $past(sreg[CALBX_FC]));
  endproperty
  a_adc: assert property (p_adc)
    else $error("add with carry result wrong");

  property p_conjunction_imm_op_c;
    @(posedge pclk) disable iff (!presetn)
      (go && alu.op == conjunction_imm_op) |=>
        sreg[CALBX_FC] == $past(sreg[CALBX_FC]) && !sreg[CALBX_FV];
  endproperty
  a_conjunction_imm_op_c: assert property (p_conjunction_imm_op_c)
    else $error("and immediate touched carry");

  property p_cbr;
    @(posedge pclk) disable iff (!presetn)
      (go && alu.op == mask_clear_bits_op) |=>
        result[7:0] == ($past(opnd_dst) & ~$past(opnd_src));
  endproperty
  a_cbr: assert property (p_cbr)
    else $error("mask clear result wrong");

  property p_fraction_unsigned_product_op;
    @(posedge pclk) disable iff (!presetn)
      (go && alu.op == fraction_unsigned_product_op) |=>
        result == 16'(($past(opnd_dst) * $past(opnd_src)) << 1);
  endproperty
  a_fraction_unsigned_product_op: assert property (p_fraction_unsigned_product_op)
    else $error("fractional product wrong");

  c_mul: cover property (@(posedge pclk) go && alu.op == signed_product_op);
  c_ret: cover property (@(posedge pclk) go && alu.op == subroutine_exit_op);
  c_pair_sum_imm_op: cover property (@(posedge pclk) go && alu.op == pair_sum_imm_op);

endmodule
`default_nettype wire

// ### tb/tb.sv
/*
  Self-checking bench for the execution unit: runs each operation group except XOR and the no-op
  over APB and compares result, flags, program counter and cycle cost.
  Assumes the register map of the calbx package and a design that raises
  pready to end each access.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import calbx_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          failures;
  int          compares;
  int          cyc;

  calbx_top i_calbx_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Totals: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // One idle edge after each transfer keeps every signal to one update
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [15:0] ar8(input logic sub,
      input logic [7:0] si, a, b, input logic c);
    logic [8:0] w;
    logic [4:0] h;
    logic [7:0] f;
    w = sub ? {1'b0, a} - {1'b0, b} - c : {1'b0, a} + {1'b0, b} + c;
    h = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - c
            : {1'b0, a[3:0]} + {1'b0, b[3:0]} + c;
    f = si;
    f[CALBX_FC] = w[8];
    f[CALBX_FZ] = (w[7:0] == 8'h00);
    f[CALBX_FN] = w[7];
    f[CALBX_FV] = ((a[7] ^ b[7]) == sub) && (w[7] != a[7]);
    f[CALBX_FH] = h[4];
    return {f, w[7:0]};
  endfunction

  function automatic logic [23:0] ar16(input logic sub,
      input logic [7:0] si, input logic [15:0] a, input logic [5:0] k);
    logic [16:0] w;
    logic [7:0]  f;
    w = sub ? {1'b0, a} - {11'h0, k} : {1'b0, a} + {11'h0, k};
    f = si;
    f[CALBX_FC] = w[16];
    f[CALBX_FZ] = (w[15:0] == 16'h0000);
    f[CALBX_FN] = w[15];
    f[CALBX_FV] = sub ? (a[15] & ~w[15]) : (~a[15] & w[15]);
    f[CALBX_FS] = f[CALBX_FN] ^ f[CALBX_FV];
    return {f, w[15:0]};
  endfunction

  // S is left out of byte-op flag compares (fm 2F): of the byte-op rules only AND immediate names S
  task automatic run_op(input calbx_op_t op, input logic [7:0] d, s, hi,
      input logic [15:0] ptr, stk, input logic [7:0] si,
      input logic [15:0] er, rm, input logic [7:0] es, fm,
      input logic [15:0] epc, input logic [2:0] ec);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, CALBX_SREG_ADDR, {24'h0, si}, rd, e);
    apb(1'b1, CALBX_PC_ADDR, 32'h0000_0100, rd, e);
    apb(1'b1, CALBX_OPND_ADDR, {8'h00, hi, s, d}, rd, e);
    apb(1'b1, CALBX_PAIR_ADDR, {stk, ptr}, rd, e);
    apb(1'b1, CALBX_CTRL_ADDR, {23'h0, 1'b1, 3'h0, op}, rd, e);
    apb(1'b0, CALBX_RES_ADDR, 32'h0, rd, e);
    chk((rd[15:0] & rm) === (er & rm), "result");
    apb(1'b0, CALBX_SREG_ADDR, 32'h0, rd, e);
    chk((rd[7:0] & fm) === (es & fm), "flags");
    apb(1'b0, CALBX_PC_ADDR, 32'h0, rd, e);
    chk(rd[15:0] === epc, "program counter");
    apb(1'b0, CALBX_STAT_ADDR, 32'h0, rd, e);
    chk(rd[10:8] === ec && rd[0] === 1'b0 && e === 1'b0, "cycle count");
  endtask

  task automatic byte_ar(input calbx_op_t op, input logic sub, cy,
                         input logic [7:0] d, s, si);
    logic [15:0] x;
    x = ar8(sub, si, d, s, cy & si[CALBX_FC]);
    // Borrow chains only keep zero when it was already set
    if (sub && cy) x[8 + CALBX_FZ] = x[8 + CALBX_FZ] & si[CALBX_FZ];
    run_op(op, d, s, 8'h00, 16'h0, 16'h0, si, {8'h00, x[7:0]}, 16'h00FF,
           x[15:8], 8'h2F, 16'h0101, CALBX_CYC1);
  endtask

  task automatic lg_op(input calbx_op_t op, input logic [7:0] d, s, r,
                       input logic cset);
    logic [7:0] f;
    f = cset ? 8'h0C : 8'h2D;
    f[CALBX_FZ] = (r == 8'h00);
    f[CALBX_FN] = r[7];
    f[CALBX_FV] = 1'b0;
    if (cset) f[CALBX_FC] = 1'b1;
    run_op(op, d, s, 8'h00, 16'h0, 16'h0, cset ? 8'h0C : 8'h2D,
           {8'h00, r}, 16'h00FF, f, 8'h2F, 16'h0101, CALBX_CYC1);
  endtask

  // Upper source bits set on purpose: only six bits form the constant
  task automatic pair_op(input calbx_op_t op, input logic sub,
                         input logic [15:0] p, input logic [5:0] k);
    logic [23:0] x;
    x = ar16(sub, 8'h20, p, k);
    run_op(op, p[7:0], {2'b11, k}, p[15:8], 16'h0, 16'h0, 8'h20,
           x[15:0], 16'hFFFF, x[23:16], 8'h3F, 16'h0101, CALBX_CYC2);
  endtask

  task automatic mul_op(input calbx_op_t op, input logic [7:0] d, s);
    logic [15:0] a, b, p, o;
    logic [7:0]  f;
    a = {{8{d[7] & (op inside {signed_product_op, mixed_sign_product_op,
          fraction_signed_product_op, fraction_mixed_product_op})}}, d};
    b = {{8{s[7] & (op inside {signed_product_op,
          fraction_signed_product_op})}}, s};
    p = a * b;
    o = (op >= fraction_unsigned_product_op) ? {p[14:0], 1'b0} : p;
    f = 8'h1E;
    f[CALBX_FC] = p[15];
    f[CALBX_FZ] = (o == 16'h0000);
    run_op(op, d, s, 8'h00, 16'h0, 16'h0, 8'h1E, o, 16'hFFFF, f, 8'h3F,
           16'h0101, CALBX_CYC2);
  endtask

  task automatic flow_op(input calbx_op_t op, input logic [7:0] s,
      input logic [15:0] ptr, stk, epc, input logic [2:0] ec);
    run_op(op, 8'h00, s, 8'h00, ptr, stk, 8'h2A, 16'h0, 16'h0, 8'h2A,
           8'h3F, epc, ec);
  endtask

  task automatic t_reset();
    logic [31:0] rd;
    logic        e;
    chk(pready === 1'b1, "pready after reset");
    apb(1'b0, CALBX_SREG_ADDR, 32'h0, rd, e);
    chk(rd[7:0] === CALBX_SREG_RESET, "flags reset");
    apb(1'b0, CALBX_PC_ADDR, 32'h0, rd, e);
    chk(rd[15:0] === CALBX_PC_RESET, "pc reset");
    apb(1'b0, CALBX_STAT_ADDR, 32'h0, rd, e);
    chk(rd === 32'h0 && e === 1'b0, "status reset");
    apb(1'b0, 8'h1C, 32'h0, rd, e);
    chk(e === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF, rd, e);
    chk(e === 1'b1, "unmapped write");
    $display("test reset and map done");
  endtask

  task automatic t_arith();
    byte_ar(CALBX_SUM_CARRY_OP, 1'b0, 1'b1, 8'hFF, 8'h00, 8'h01);
    byte_ar(CALBX_SUM_CARRY_OP, 1'b0, 1'b1, 8'h7F, 8'h00, 8'h21);
    byte_ar(CALBX_SUM_CARRY_OP, 1'b0, 1'b1, 8'h3C, 8'h45, 8'h3E);
    byte_ar(difference_imm_op, 1'b1, 1'b0, 8'h10, 8'h01, 8'h00);
    byte_ar(difference_imm_op, 1'b1, 1'b0, 8'h80, 8'h01, 8'h01);
    byte_ar(difference_imm_op, 1'b1, 1'b0, 8'h00, 8'h01, 8'h00);
    byte_ar(difference_with_borrow_op, 1, 1, 8'h05, 8'h04, 8'h03);
    byte_ar(difference_with_borrow_op, 1, 1, 8'h05, 8'h04, 8'h01);
    byte_ar(difference_with_borrow_op, 1, 1, 8'h00, 8'h00, 8'h01);
    byte_ar(difference_imm_borrow_op, 1, 1, 8'h80, 8'h00, 8'h01);
    byte_ar(difference_imm_borrow_op, 1, 1, 8'h20, 8'h1F, 8'h02);
    $display("test byte arithmetic done");
  endtask

  task automatic t_logic();
    logic [15:0] x;
    lg_op(conjunction_imm_op, 8'hF0, 8'h0F, 8'h00, 1'b0);
    lg_op(conjunction_imm_op, 8'hC3, 8'h81, 8'h81, 1'b0);
    lg_op(disjunction_imm_op, 8'h00, 8'h00, 8'h00, 1'b0);
    lg_op(disjunction_imm_op, 8'h40, 8'h80, 8'hC0, 1'b0);
    lg_op(self_conjunction_test_op, 8'h80, 8'h55, 8'h80, 1'b0);
    lg_op(self_conjunction_test_op, 8'h00, 8'h55, 8'h00, 1'b0);
    lg_op(mask_set_bits_op, 8'h01, 8'h80, 8'h81, 1'b0);
    lg_op(mask_clear_bits_op, 8'hFF, 8'h0F, 8'hF0, 1'b0);
    lg_op(mask_clear_bits_op, 8'h0F, 8'h0F, 8'h00, 1'b0);
    lg_op(bitwise_invert_op, 8'hFF, 8'h00, 8'h00, 1'b1);
    lg_op(bitwise_invert_op, 8'h35, 8'h00, 8'hCA, 1'b1);
    x = ar8(1'b1, 8'h00, 8'h00, 8'h80, 1'b0);
    run_op(arith_invert_op, 8'h80, 8'h00, 8'h00, 16'h0, 16'h0, 8'h00,
           x, 16'h00FF, x[15:8], 8'h2F, 16'h0101, CALBX_CYC1);
    x = ar8(1'b1, 8'h00, 8'h00, 8'h01, 1'b0);
    run_op(arith_invert_op, 8'h01, 8'h00, 8'h00, 16'h0, 16'h0, 8'h00,
           x, 16'h00FF, x[15:8], 8'h2F, 16'h0101, CALBX_CYC1);
    $display("test logic done");
  endtask

  task automatic t_pair();
    pair_op(pair_sum_imm_op, 1'b0, 16'hFFFF, 6'h01);
    pair_op(pair_sum_imm_op, 1'b0, 16'h7FFF, 6'h01);
    pair_op(pair_sum_imm_op, 1'b0, 16'h0000, 6'h3F);
    pair_op(pair_difference_imm_op, 1'b1, 16'h0000, 6'h01);
    pair_op(pair_difference_imm_op, 1'b1, 16'h8000, 6'h01);
    pair_op(pair_difference_imm_op, 1'b1, 16'h0001, 6'h01);
    $display("test pair arithmetic done");
  endtask

  task automatic t_mul();
    calbx_op_t op;
    for (int i = 0; i < 6; i++) begin
      op = calbx_op_t'(5'(int'(unsigned_product_op) + i));
      mul_op(op, 8'h80, 8'h80);
      mul_op(op, 8'hFF, 8'h02);
      mul_op(op, 8'h00, 8'h55);
      mul_op(op, 8'h7F, 8'h81);
    end
    $display("test multiply done");
  endtask

  task automatic t_flow();
    logic [31:0] rd;
    logic        e;
    flow_op(relative_jump_op, 8'h10, 16'h0, 16'h0, 16'h0111,
            CALBX_CYC2);
    flow_op(relative_jump_op, 8'hFE, 16'h0, 16'h0, 16'h00FF,
            CALBX_CYC2);
    flow_op(pointer_jump_op, 8'h00, 16'hABCD, 16'h0, 16'hABCD,
            CALBX_CYC2);
    flow_op(absolute_jump_op, 8'h00, 16'h1234, 16'h0, 16'h1234, CALBX_CYC3);
    flow_op(relative_subroutine_op, 8'h80, 16'h0, 16'h0, 16'h0081,
            CALBX_CYC3);
    flow_op(pointer_subroutine_op, 8'h00, 16'h2468, 16'h0, 16'h2468,
            CALBX_CYC3);
    flow_op(CALBX_ABS_CALL_OP, 8'h00, 16'h1357, 16'h0, 16'h1357,
            CALBX_CYC4);
    flow_op(subroutine_exit_op, 8'h00, 16'h0, 16'h9ABC, 16'h9ABC,
            CALBX_CYC4);
    // A write landing while the return is still busy must be ignored
    apb(1'b1, CALBX_CTRL_ADDR, {23'h0, 1'b1, 3'h0, subroutine_exit_op},
        rd, e);
    apb(1'b1, CALBX_PC_ADDR, 32'h0000_5555, rd, e);
    apb(1'b0, CALBX_PC_ADDR, 32'h0, rd, e);
    chk(rd[15:0] === 16'h9ABC, "write while busy");
    $display("test program flow done");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_arith();
    t_logic();
    t_pair();
    t_mul();
    t_flow();
    print_verdict();
  end
endmodule
`default_nettype wire
